// *** rtl/rtc_alarm_pkg.sv ***
// Purpose: Constants and carriers for the alarm hour and weekday set points
// Assumes: 32-bit AXI4-Lite register access, one clock
// Notes: Printed offsets are register indexes; byte address is index * 4
//
// Behaviour
// - In BCD mode bits 7:4 of the alarm hour hold the tens digit, 0 to 2.
// - In BCD mode bits 3:0 of the alarm hour hold the ones digit, 0 to 9.
// - In binary mode all eight alarm hour bits are one value, 0x00 to 0x17.
// - The alarm hour keeps its value through reset and is always read/write.
// - The upper nibble of the alarm weekday is read-only and reads zero.
// - The weekday nibble is written only while unlocked and survives reset.
// - The BCD select bit picks BCD for counts and set points, else binary.
// - The weekday value sits in the low nibble, 1 to 7, upper nibble zero.
// - Unlock bit zero means locked and counting; one means writable, stopped.
// - The hour comparison joins the alarm only when enable bit 2 is set.
package rtc_alarm_pkg;

    // ==========================================================
    // Register indexes
    localparam logic [7:0] IDX_ALARM_HOUR = 8'hEA;
    localparam logic [7:0] IDX_ALARM_WEEKDAY = 8'hEB;
    localparam logic [7:0] IDX_ALARM_CTRL = 8'hEC;
    localparam logic [7:0] IDX_CLOCK_CTRL = 8'hED;

    // ==========================================================
    // Field positions
    localparam int HOUR_ALARM_ENABLE_BIT = 2;
    localparam int WEEKDAY_ALARM_ENABLE_BIT = 3;
    localparam int CLOCK_UNLOCK_BIT = 0;
    localparam int BCD_SELECT_BIT = 5;

    // ==========================================================
    // Values after reset, legal limits and response codes
    localparam logic [3:0] ALARM_CTRL_RESET = 4'h0;
    localparam logic UNLOCK_RESET = 1'b0;
    localparam logic [3:0] HOUR_TENS_MAX = 4'h2;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [7:0] HOUR_BIN_MAX = 8'h17;
    localparam logic [3:0] WEEKDAY_MIN = 4'h1;
    localparam logic [3:0] WEEKDAY_MAX = 4'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] hour;
        logic [3:0] weekday;
    } setpoints_t;

    typedef struct packed {
        logic hour_enable;
        logic weekday_enable;
    } alarm_enables_t;

endpackage

// *** rtl/setpoint_match.sv ***
// Purpose: Compares the alarm set points with the current clock counts
// Assumes: Counts arrive from logic on the same clock
// Notes: Disabled fields count as matched so the alarm can AND all fields
`timescale 1ns/10ps
module setpoint_match
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire rtc_alarm_pkg::setpoints_t setpoints,
    input wire rtc_alarm_pkg::setpoints_t counts,
    input wire rtc_alarm_pkg::alarm_enables_t enables,
    output logic hour_match,
    output logic weekday_match
);
    // ==========================================================
    // Registered compare
    // Raw compare: counts and set points share one encoding
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hour_match <= 1'b0;
            weekday_match <= 1'b0;
        end
        else
        begin
            hour_match <= !enables.hour_enable
                || (setpoints.hour == counts.hour);
            weekday_match <= !enables.weekday_enable
                || (setpoints.weekday == counts.weekday);
        end
    end
endmodule

// *** rtl/alarm_setpoints.sv ***
// Purpose: AXI4-Lite register block for alarm hour and weekday set points
// Assumes: Clock counts come from the clock counter on the same clock
// Notes: Set point storage has no reset; it holds whatever was last written
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
module alarm_setpoints
#(
    parameter int ADDR_W = 12
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire rtc_alarm_pkg::setpoints_t clock_counts,
    output logic bcd_select,
    output logic counter_run,
    output logic hour_match,
    output logic weekday_match,
    output logic hour_setpoint_legal,
    output logic weekday_setpoint_legal
);
    // ==========================================================
    // Parameter check
    if (ADDR_W < 10 || ADDR_W > 32)
    begin : g_bad_addr
        $error("ADDR_W must be 10 to 32");
    end

    // ==========================================================
    // Helpers
    function automatic logic hour_ok(input logic [7:0] h, input logic bcd);
        if (bcd)
            hour_ok = (h[7:4] <= rtc_alarm_pkg::HOUR_TENS_MAX)
                && (h[3:0] <= rtc_alarm_pkg::DIGIT_MAX)
                && (h <= 8'h23);
        else
            hour_ok = h <= rtc_alarm_pkg::HOUR_BIN_MAX;
    endfunction

    function automatic logic [1:0] decode(input logic [ADDR_W-1:0] a);
        // Returns 0..3 for the four registers; unmapped is flagged apart
        decode = a[3:2] - rtc_alarm_pkg::IDX_ALARM_HOUR[1:0];
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = int'(a[ADDR_W-1:2]) >= int'(rtc_alarm_pkg::IDX_ALARM_HOUR)
            && int'(a[ADDR_W-1:2]) <= int'(rtc_alarm_pkg::IDX_CLOCK_CTRL);
    endfunction

    // ==========================================================
    // State
    rtc_alarm_pkg::setpoints_t setpoints_ff;
    rtc_alarm_pkg::alarm_enables_t enables_ff;
    logic bcd_ff;
    logic unlock_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic wr_fire;
    logic [1:0] wr_sel;
    logic wr_lane0;
    logic [1:0] loaded_ff; // Set once written; checks skip the unknown start

    assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aresetn && aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign wr_sel = decode(awaddr_ff);
    assign wr_lane0 = wr_fire && mapped(awaddr_ff) && wstrb_ff[0];

    // ==========================================================
    // Write channel capture, either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_held_ff <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_held_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rtc_alarm_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(awaddr_ff) ? rtc_alarm_pkg::RESP_OKAY
                : rtc_alarm_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ==========================================================
    // Set points: no reset so software values survive it
    always_ff @(posedge aclk)
    begin
        if (wr_lane0 && wr_sel == 2'd0)
            setpoints_ff.hour <= wdata_ff[7:0];
        if (wr_lane0 && wr_sel == 2'd1 && unlock_ff)
            setpoints_ff.weekday <= wdata_ff[3:0];
        if (wr_lane0 && wr_sel == 2'd0)
            loaded_ff[0] <= 1'b1;
        if (wr_lane0 && wr_sel == 2'd1 && unlock_ff)
            loaded_ff[1] <= 1'b1;
    end

    // Select bit keeps its value through reset, like the set points
    always_ff @(posedge aclk)
    begin
        if (wr_lane0 && wr_sel == 2'd3)
            bcd_ff <= wdata_ff[rtc_alarm_pkg::BCD_SELECT_BIT];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enables_ff <= rtc_alarm_pkg::ALARM_CTRL_RESET[3:2];
            unlock_ff <= rtc_alarm_pkg::UNLOCK_RESET;
        end
        else if (wr_lane0)
        begin
            if (wr_sel == 2'd2)
            begin
                enables_ff.hour_enable <=
                    wdata_ff[rtc_alarm_pkg::HOUR_ALARM_ENABLE_BIT];
                enables_ff.weekday_enable <=
                    wdata_ff[rtc_alarm_pkg::WEEKDAY_ALARM_ENABLE_BIT];
            end
            if (wr_sel == 2'd3)
                unlock_ff <= wdata_ff[rtc_alarm_pkg::CLOCK_UNLOCK_BIT];
        end
    end

    // ==========================================================
    // Read channel
    logic [1:0] rd_sel;
    logic [7:0] rd_byte;
    assign rd_sel = decode(s_axi_araddr);

    always_comb
    begin
        unique case (rd_sel)
            2'd0: rd_byte = setpoints_ff.hour;
            2'd1: rd_byte = {4'h0, setpoints_ff.weekday};
            2'd2: rd_byte = {4'h0, enables_ff.weekday_enable,
                             enables_ff.hour_enable, 2'b00};
            2'd3: rd_byte = {2'b00, bcd_ff, 4'h0, unlock_ff};
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= rtc_alarm_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= mapped(s_axi_araddr) ? {24'h0, rd_byte} : '0;
            s_axi_rresp <= mapped(s_axi_araddr) ? rtc_alarm_pkg::RESP_OKAY
                : rtc_alarm_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ==========================================================
    // Outputs
    assign bcd_select = bcd_ff;
    assign counter_run = !unlock_ff;
    assign hour_setpoint_legal = hour_ok(setpoints_ff.hour, bcd_ff);
    assign weekday_setpoint_legal =
        (setpoints_ff.weekday >= rtc_alarm_pkg::WEEKDAY_MIN)
        && (setpoints_ff.weekday <= rtc_alarm_pkg::WEEKDAY_MAX);

    setpoint_match u_match
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .setpoints(setpoints_ff),
        .counts(clock_counts),
        .enables(enables_ff),
        .hour_match(hour_match),
        .weekday_match(weekday_match)
    );

    // ==========================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_both_held;
        aw_held_ff && w_held_ff && !s_axi_bvalid;
    endsequence
    sequence s_answer;
        s_axi_bvalid;
    endsequence

    a_write_answer_next: assert property (
        s_both_held |=> s_answer)
        else $error("write not answered one cycle after capture");

    a_hour_write_lands: assert property (
        wr_lane0 && wr_sel == 2'd0
        |=> setpoints_ff.hour == $past(wdata_ff[7:0]))
        else $error("alarm hour write lost");

    a_hour_reset_keeps: assert property (
        @(posedge aclk) disable iff (1'b0)
        !aresetn && loaded_ff[0] |=> $stable(setpoints_ff.hour))
        else $error("alarm hour disturbed by reset");

    a_weekday_locked_hold: assert property (
        wr_fire && !unlock_ff && loaded_ff[1]
        |=> $stable(setpoints_ff.weekday))
        else $error("weekday changed while locked");

    a_weekday_unlocked_wr: assert property (
        wr_lane0 && wr_sel == 2'd1 && unlock_ff
        |=> setpoints_ff.weekday == $past(wdata_ff[3:0]))
        else $error("weekday write lost while unlocked");

    a_weekday_upper_zero: assert property (
        s_axi_arvalid && s_axi_arready && mapped(s_axi_araddr)
        && rd_sel == 2'd1 |=> s_axi_rvalid && s_axi_rdata[31:4] == '0)
        else $error("weekday upper bits not zero");

    a_bcd_tens_legal: assert property (
        bcd_ff && setpoints_ff.hour[7:4] > 4'h2 |-> !hour_setpoint_legal)
        else $error("bcd tens above two taken as legal");

    a_bcd_ones_legal: assert property (
        bcd_ff && setpoints_ff.hour[3:0] > 4'h9 |-> !hour_setpoint_legal)
        else $error("bcd ones above nine taken as legal");

    a_bin_hour_legal: assert property (
        !bcd_ff |-> hour_setpoint_legal == (setpoints_ff.hour <= 8'h17))
        else $error("binary hour range wrong");

    a_hour_gate_off: assert property (
        !enables_ff.hour_enable |=> hour_match)
        else $error("hour compare active while disabled");

    a_hour_compare: assert property (
        enables_ff.hour_enable
        |=> hour_match == ($past(setpoints_ff.hour)
                           == $past(clock_counts.hour)))
        else $error("hour compare wrong");
endmodule

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for the alarm hour and weekday set points
// Assumes: Bench is the AXI4-Lite master; inputs change by NBA at posedge
// Notes: Readies and answers are taken at the rising edge that moves them
`timescale 1ns/10ps
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [11:0] araddr = 12'h000;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    rtc_alarm_pkg::setpoints_t counts = '0;
    logic bcd_sel, run, h_match, w_match, h_legal, w_legal;
    int n_mismatch = 0;
    int total_checks = 0;
    localparam logic [11:0] A_HOUR = 12'h3A8;
    localparam logic [11:0] A_WDAY = 12'h3AC;
    localparam logic [11:0] A_ACTRL = 12'h3B0;
    localparam logic [11:0] A_CCTRL = 12'h3B4;
    localparam logic [11:0] A_NONE = 12'h3C0;
    localparam logic [1:0] OK = rtc_alarm_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = rtc_alarm_pkg::RESP_SLVERR;

    always #5 aclk = ~aclk;

    alarm_setpoints #(.ADDR_W(12)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .clock_counts(counts),
        .bcd_select(bcd_sel), .counter_run(run), .hour_match(h_match),
        .weekday_match(w_match), .hour_setpoint_legal(h_legal),
        .weekday_setpoint_legal(w_legal));

    // ==========================================================
    // Verdict and comparisons
    task automatic conclude();
        if (n_mismatch == 0 && total_checks > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask

    task automatic stuck();
        n_mismatch++;
        $display("ERROR %0t bus handshake timed out", $time);
        conclude();
    endtask

    // ==========================================================
    // Bus cycles
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        // A fresh edge keeps back-to-back calls from retouching a strobe
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid && n < 50);
        if (!bvalid)
            stuck();
        chk32({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] ed,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid && n < 50);
        if (!rvalid)
            stuck();
        chk32(rdata, {24'h0, ed});
        chk32({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
    endtask

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    task automatic settle();
        repeat (3) @(posedge aclk);
        @(negedge aclk);
    endtask

    // ==========================================================
    // Hour table: {bcd, value, legal}
    logic [9:0] hours [8] = '{{1'b1, 8'h23, 1'b1}, {1'b1, 8'h19, 1'b1},
        {1'b1, 8'h2A, 1'b0}, {1'b1, 8'h30, 1'b0}, {1'b1, 8'h24, 1'b0},
        {1'b0, 8'h17, 1'b1}, {1'b0, 8'h18, 1'b0}, {1'b0, 8'h00, 1'b1}};

    initial
    begin
        @(posedge aclk);
        do_reset();
        chk1(run, 1'b1);
        rd(A_ACTRL, 8'h00, OK);
        foreach (hours[i])
        begin
            wr(A_CCTRL, {2'b00, hours[i][9], 5'h01}, OK);
            @(negedge aclk);
            chk1(bcd_sel, hours[i][9]);
            chk1(run, 1'b0);
            wr(A_HOUR, hours[i][8:1], OK);
            rd(A_HOUR, hours[i][8:1], OK);
            @(negedge aclk);
            chk1(h_legal, hours[i][0]);
        end
        wr(A_WDAY, 8'hF7, OK);
        rd(A_WDAY, 8'h07, OK);
        @(negedge aclk);
        chk1(w_legal, 1'b1);
        wr(A_WDAY, 8'h08, OK);
        rd(A_WDAY, 8'h08, OK);
        @(negedge aclk);
        chk1(w_legal, 1'b0);
        wr(A_WDAY, 8'h00, OK);
        @(negedge aclk);
        chk1(w_legal, 1'b0);
        wr(A_WDAY, 8'h01, OK);
        // Locked: weekday keeps its value, hour stays writable
        wr(A_CCTRL, 8'h00, OK);
        @(negedge aclk);
        chk1(run, 1'b1);
        wr(A_WDAY, 8'h05, OK);
        rd(A_WDAY, 8'h01, OK);
        wr(A_HOUR, 8'h15, OK);
        rd(A_HOUR, 8'h15, OK);
        // Matching against counts
        @(posedge aclk);
        counts <= '{hour: 8'h10, weekday: 4'h2};
        settle();
        chk1(h_match, 1'b1);
        chk1(w_match, 1'b1);
        wr(A_ACTRL, 8'h0C, OK);
        settle();
        chk1(h_match, 1'b0);
        chk1(w_match, 1'b0);
        @(posedge aclk);
        counts <= '{hour: 8'h15, weekday: 4'h1};
        settle();
        chk1(h_match, 1'b1);
        chk1(w_match, 1'b1);
        // Only bit 2 gates the hour compare
        wr(A_ACTRL, 8'h08, OK);
        rd(A_ACTRL, 8'h08, OK);
        @(posedge aclk);
        counts <= '{hour: 8'h10, weekday: 4'h1};
        settle();
        chk1(h_match, 1'b1);
        chk1(w_match, 1'b1);
        wr(A_ACTRL, 8'h04, OK);
        settle();
        chk1(h_match, 1'b0);
        rd(A_NONE, 8'h00, ERR);
        wr(A_NONE, 8'h55, ERR);
        // Second reset: set points survive, alarm control and unlock clear
        do_reset();
        chk1(run, 1'b1);
        rd(A_HOUR, 8'h15, OK);
        rd(A_WDAY, 8'h01, OK);
        rd(A_ACTRL, 8'h00, OK);
        conclude();
    end
endmodule
